// ---- logic/cbt_pkg.sv ----
// Package for the CAN bus pin and bit timing block.
// Assumes one clock domain and a plain strobe register port.
package cbt_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [3:0] ADDR_BUS_PIN_CONTROL    = 4'h0;
   localparam logic [3:0] ADDR_BIT_RATE_PRESCALER = 4'h1;
   localparam logic [3:0] ADDR_BIT_SEGMENT_TIMING = 4'h2;
   localparam logic [3:0] ADDR_TX_DATA_FIRST      = 4'h3;
   localparam logic [3:0] ADDR_TX_DATA_SECOND     = 4'h4;
   localparam logic [3:0] ADDR_RX_DATA_FIRST      = 4'h5;
   localparam logic [3:0] ADDR_RX_DATA_SECOND     = 4'h6;
   localparam logic [3:0] ADDR_WAKE_CONTROL      = 4'h7;
   localparam logic [3:0] ADDR_IRQ_STATUS         = 4'h8;
   localparam logic [3:0] ADDR_IRQ_ENABLE         = 4'h9;
   localparam logic [3:0] ADDR_IRQ_CLEAR          = 4'hA;
   localparam logic [3:0] ADDR_BIT_STATUS         = 4'hB;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_DRIVE_ENABLE_LOW_LINE  = 4;
   localparam int BIT_DRIVE_ENABLE_HIGH_LINE = 5;
   localparam int BIT_RX_REF_SELECT_SECOND   = 3;
   localparam int BIT_RX_REF_SELECT_FIRST    = 2;
   localparam int BIT_PROP_LSB               = 5;
   localparam int BIT_PHASE_LSB              = 2;
   localparam int BIT_WAKE_ENABLE            = 0;
   localparam int BIT_IRQ_WAKE               = 0;
   localparam int BIT_IRQ_BIT_END            = 1;
   // ----------------------------------------
   // Reset values and limits
   // ----------------------------------------
   localparam logic [7:0] RST_BUS_PIN_CONTROL    = 8'h00;
   localparam logic [7:0] RST_BIT_RATE_PRESCALER = 8'h00;
   localparam logic [7:0] RST_BIT_SEGMENT_TIMING = 8'h00;
   localparam logic [3:0] SJW_MAX                = 4'h4;
   localparam logic [7:0] DATA_ZERO              = 8'h00;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {CBT_SYNC, CBT_PROP, CBT_PHASE1, CBT_PHASE2} cbt_seg_e;
   typedef struct packed {
      logic drive_out_first_o;
      logic drive_out_first_oe;
      logic drive_out_second_o;
      logic drive_out_second_oe;
   } cbt_drive_s;
endpackage : cbt_pkg

// ---- logic/cbt_can_phy.sv ----
// CAN pin control, receive routing, wake-up and bit timing generator.
// Assumes comparator results arrive as synchronous digital inputs.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// - Two drive outputs each gated by own enable; either enables interface.
// - Dominant pulls first output low, second high; recessive floats both.
// - Each receive comparator input can switch to half-supply reference.
// - Two wake comparators against reference merge into one wake signal.
// - Fixed variant: wake always on, falling edge, software cannot disable.
// - Other variant: wake gated by software wake enable bit.
// - Low drive enable bit 4, high bit 5; differential both set.
// - Second reference select bit 3; low line single wire mode.
// - First reference select bit 2; high line single wire mode.
// - Pending wake flag blocks idle and halt entry.
// - Phase segments are n+1 quanta; jump width same, capped at four.
// - Bit rate is clock over (1+prescaler) times (1+2PS+PROPAGATION_SEGMENT_LENGTH).
// - Timing bits 7:5 propagation, 4:2 phase, length minus one.
// - Two transmit and two receive data byte registers.
// - Passive 2.0B: extended frames tolerated, standard frames only handled.
module cbt_can_phy #(
   parameter bit FIXED_WAKE = 1'b1
) (
   input  wire logic            clock,
   input  wire logic            rst_n,
   input  wire logic [3:0]      addr,
   input  wire logic [7:0]      wdata,
   input  wire logic            wr,
   input  wire logic            rd,
   output logic      [7:0]      rdata,
   input  wire logic            tx_dominant,
   output cbt_pkg::cbt_drive_s  drive,
   output logic                 interface_enable,
   input  wire logic            cmp_first_above_ref,
   input  wire logic            cmp_second_above_ref,
   input  wire logic            cmp_first_above_second,
   input  wire logic            wake_cmp_first,
   input  wire logic            wake_cmp_second,
   output logic                 rx_bit,
   output logic                 wake_signal,
   output logic                 wake_pending,
   input  wire logic            lowpower_request,
   output logic                 lowpower_grant,
   output logic                 sample_point,
   output logic                 bit_end,
   output logic      [3:0]      sync_jump_width,
   output logic                 irq
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] bus_pin_control;
   logic [7:0] bit_rate_prescaler;
   logic [7:0] bit_segment_timing;
   logic [7:0] tx_data [2];
   logic [7:0] rx_data [2];
   logic       wake_enable;
   logic [1:0] irq_status;
   logic [1:0] irq_enable;
   logic       wake_prev;
   logic       wake_event;
   logic       clear_write;
   logic [7:0] next_rdata;

   assign clear_write = wr && (addr == cbt_pkg::ADDR_IRQ_CLEAR);

   // One process per register, except the data bytes, where tx and rx byte b share one
   // Writes to unmapped or read-only offsets are dropped
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bus_pin_control <= cbt_pkg::RST_BUS_PIN_CONTROL;
      end else if (wr && addr == cbt_pkg::ADDR_BUS_PIN_CONTROL) begin
         bus_pin_control <= wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bit_rate_prescaler <= cbt_pkg::RST_BIT_RATE_PRESCALER;
      end else if (wr && addr == cbt_pkg::ADDR_BIT_RATE_PRESCALER) begin
         bit_rate_prescaler <= wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bit_segment_timing <= cbt_pkg::RST_BIT_SEGMENT_TIMING;
      end else if (wr && addr == cbt_pkg::ADDR_BIT_SEGMENT_TIMING) begin
         bit_segment_timing <= wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wake_enable <= 1'b0;
      end else if (wr && addr == cbt_pkg::ADDR_WAKE_CONTROL) begin
         wake_enable <= wdata[cbt_pkg::BIT_WAKE_ENABLE];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irq_enable <= 2'h0;
      end else if (wr && addr == cbt_pkg::ADDR_IRQ_ENABLE) begin
         irq_enable <= wdata[1:0];
      end
   end

   // Data bytes; the frame engine outside owns transfer, these only hold bytes
   for (genvar b = 0; b < 2; b++) begin : g_data
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            tx_data[b] <= cbt_pkg::DATA_ZERO;
            rx_data[b] <= cbt_pkg::DATA_ZERO;
         end else if (wr) begin
            if (addr == cbt_pkg::ADDR_TX_DATA_FIRST + 4'(b)) begin
               tx_data[b] <= wdata;
            end
            if (addr == cbt_pkg::ADDR_RX_DATA_FIRST + 4'(b)) begin
               rx_data[b] <= wdata;
            end
         end
      end
   end

   // ----------------------------------------
   // Drive outputs and receive routing
   // ----------------------------------------
   logic en_low;
   logic en_high;
   logic ref_first;
   logic ref_second;
   assign en_low     = bus_pin_control[cbt_pkg::BIT_DRIVE_ENABLE_LOW_LINE];
   assign en_high    = bus_pin_control[cbt_pkg::BIT_DRIVE_ENABLE_HIGH_LINE];
   assign ref_first  = bus_pin_control[cbt_pkg::BIT_RX_REF_SELECT_FIRST];
   assign ref_second = bus_pin_control[cbt_pkg::BIT_RX_REF_SELECT_SECOND];

   assign interface_enable = en_low | en_high;

   // Outputs register the drive so pins change cleanly on a clock edge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         drive <= '0;
      end else begin
         drive.drive_out_first_o   <= 1'b0;
         drive.drive_out_first_oe  <= en_low & tx_dominant;
         drive.drive_out_second_o  <= 1'b1;
         drive.drive_out_second_oe <= en_high & tx_dominant;
      end
   end

   // Comparator selects: first input to ref gives high-line single wire
   // Both inputs at the reference give no usable level, so read recessive
   logic next_rx_bit;

   always_comb begin
      case ({ref_first, ref_second})
         2'b00:   next_rx_bit = cmp_first_above_second;
         2'b01:   next_rx_bit = cmp_first_above_ref;
         2'b10:   next_rx_bit = ~cmp_second_above_ref;
         default: next_rx_bit = 1'b1;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_bit <= 1'b1;
      end else begin
         rx_bit <= next_rx_bit;
      end
   end

   // ----------------------------------------
   // Wake-up
   // ----------------------------------------
   // Inputs high mean pin above reference; merged low marks dominant level
   logic next_wake_level;
   assign next_wake_level = wake_cmp_first & ~wake_cmp_second;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wake_signal <= 1'b1;
      end else begin
         wake_signal <= next_wake_level;
      end
   end

   // Previous level starts recessive so leaving reset makes no false edge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wake_prev <= 1'b1;
      end else begin
         wake_prev <= wake_signal;
      end
   end
   // Fixed variant cannot be switched off, guarding against runaway code
   assign wake_event = wake_prev & ~wake_signal & (FIXED_WAKE | wake_enable);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wake_pending <= 1'b0;
      end else if (wake_event) begin
         wake_pending <= 1'b1;
      end else if (clear_write && wdata[cbt_pkg::BIT_IRQ_WAKE]) begin
         wake_pending <= 1'b0;
      end
   end

   // ----------------------------------------
   // Low-power handshake
   // ----------------------------------------
   // A grounded unused receive pin keeps a false wake from blocking sleep
   assign lowpower_grant = lowpower_request & ~wake_pending;

   // ----------------------------------------
   // Bit timing
   // ----------------------------------------
   logic [2:0] prop_field;
   logic [2:0] phase_field;
   logic [3:0] prop_len;
   logic [3:0] phase_len;
   logic [7:0] presc_cnt;
   logic       quantum;
   logic [3:0] seg_cnt;
   cbt_pkg::cbt_seg_e seg;
   logic [3:0] seg_len;

   assign prop_field  = bit_segment_timing[cbt_pkg::BIT_PROP_LSB +: 3];
   assign phase_field = bit_segment_timing[cbt_pkg::BIT_PHASE_LSB +: 3];
   assign prop_len    = {1'b0, prop_field} + 4'h1;
   assign phase_len   = {1'b0, phase_field} + 4'h1;
   assign sync_jump_width = (phase_len > cbt_pkg::SJW_MAX) ? cbt_pkg::SJW_MAX : phase_len;


   // Quantum = clock / (1 + prescaler)
   // A prescaler change mid-bit acts on the next count; stop the interface first
   always_ff @(posedge clock) begin
      if (!rst_n || !interface_enable) begin
         presc_cnt <= 8'h00;
      end else if (presc_cnt >= bit_rate_prescaler) begin
         presc_cnt <= 8'h00;
      end else begin
         presc_cnt <= presc_cnt + 8'h01;
      end
   end
   assign quantum = interface_enable && (presc_cnt >= bit_rate_prescaler);

   always_comb begin
      case (seg)
         cbt_pkg::CBT_SYNC:   seg_len = 4'h1;
         cbt_pkg::CBT_PROP:   seg_len = prop_len;
         cbt_pkg::CBT_PHASE1: seg_len = phase_len;
         cbt_pkg::CBT_PHASE2: seg_len = phase_len;
         default:             seg_len = 4'h1;
      endcase
   end

   // ----------------------------------------
   // Segment sequencer
   // ----------------------------------------
   logic              seg_done;
   cbt_pkg::cbt_seg_e next_seg;

   assign seg_done = quantum && (seg_cnt + 4'h1 >= seg_len);

   always_comb begin
      case (seg)
         cbt_pkg::CBT_SYNC:   next_seg = cbt_pkg::CBT_PROP;
         cbt_pkg::CBT_PROP:   next_seg = cbt_pkg::CBT_PHASE1;
         cbt_pkg::CBT_PHASE1: next_seg = cbt_pkg::CBT_PHASE2;
         default:             next_seg = cbt_pkg::CBT_SYNC;
      endcase
   end

   // Bit = sync(1) + prop + 2 x phase quanta; resynchronisation is the engine's job
   // Standard bit timing only; frame format handling lives in the engine
   always_ff @(posedge clock) begin
      if (!rst_n || !interface_enable) begin
         seg <= cbt_pkg::CBT_SYNC;
      end else if (seg_done) begin
         seg <= next_seg;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n || !interface_enable) begin
         seg_cnt <= 4'h0;
      end else if (seg_done) begin
         seg_cnt <= 4'h0;
      end else if (quantum) begin
         seg_cnt <= seg_cnt + 4'h1;
      end
   end

   // Pulses are registered, one clock after the quantum that ends the segment
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sample_point <= 1'b0;
      end else begin
         sample_point <= seg_done && seg == cbt_pkg::CBT_PHASE1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bit_end <= 1'b0;
      end else begin
         bit_end <= seg_done && seg == cbt_pkg::CBT_PHASE2;
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   // Set wins over clear so no event is lost
   logic [1:0] irq_event;
   assign irq_event[cbt_pkg::BIT_IRQ_WAKE]    = wake_event;
   assign irq_event[cbt_pkg::BIT_IRQ_BIT_END] = bit_end;

   for (genvar s = 0; s < 2; s++) begin : g_status
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            irq_status[s] <= 1'b0;
         end else if (irq_event[s]) begin
            irq_status[s] <= 1'b1;
         end else if (clear_write && wdata[s]) begin
            irq_status[s] <= 1'b0;
         end
      end
   end

   assign irq = |(irq_status & irq_enable);

   // ----------------------------------------
   // Read port
   // ----------------------------------------

   always_comb begin
      next_rdata = 8'h00;
      case (addr)
         cbt_pkg::ADDR_BUS_PIN_CONTROL:    next_rdata = bus_pin_control;
         cbt_pkg::ADDR_BIT_RATE_PRESCALER: next_rdata = bit_rate_prescaler;
         cbt_pkg::ADDR_BIT_SEGMENT_TIMING: next_rdata = bit_segment_timing;
         cbt_pkg::ADDR_TX_DATA_FIRST:      next_rdata = tx_data[0];
         cbt_pkg::ADDR_TX_DATA_SECOND:     next_rdata = tx_data[1];
         cbt_pkg::ADDR_RX_DATA_FIRST:      next_rdata = rx_data[0];
         cbt_pkg::ADDR_RX_DATA_SECOND:     next_rdata = rx_data[1];
         cbt_pkg::ADDR_WAKE_CONTROL:       next_rdata = {7'h00, wake_enable | FIXED_WAKE};
         cbt_pkg::ADDR_IRQ_STATUS:         next_rdata = {6'h00, irq_status};
         cbt_pkg::ADDR_IRQ_ENABLE:         next_rdata = {6'h00, irq_enable};
         cbt_pkg::ADDR_BIT_STATUS:         next_rdata = {sync_jump_width, 1'b0, wake_pending, seg};
         default:                          next_rdata = 8'h00;
      endcase
   end


   // Read data falls back to zero so a stale value never looks like an answer
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd ? next_rdata : 8'h00;
      end
   end
endmodule : cbt_can_phy

// ---- testbench/cbt_phy_asserts.sv ----
// Checker for the CAN pin and bit timing block.
// Sees only the top ports; bound from the bench top.
`timescale 1ns/10ps
module cbt_phy_asserts #(
   parameter bit FIXED_WAKE = 1'b1
) (
   input wire logic                clock,
   input wire logic                rst_n,
   input wire logic [3:0]          addr,
   input wire logic [7:0]          wdata,
   input wire logic                wr,
   input wire logic                tx_dominant,
   input wire cbt_pkg::cbt_drive_s drive,
   input wire logic                interface_enable,
   input wire logic                wake_signal,
   input wire logic                wake_pending,
   input wire logic                lowpower_request,
   input wire logic                lowpower_grant,
   input wire logic [3:0]          sync_jump_width
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_ctrl_wr;
      wr && addr == cbt_pkg::ADDR_BUS_PIN_CONTROL;
   endsequence
   sequence s_tim_wr;
      wr && addr == cbt_pkg::ADDR_BIT_SEGMENT_TIMING;
   endsequence
   a_iface_enable: assert property (s_ctrl_wr |=>
      interface_enable == ($past(wdata[4]) || $past(wdata[5])))
      else $error("interface enable does not follow drive enables");
   a_first_low: assert property (drive.drive_out_first_oe |-> !drive.drive_out_first_o)
      else $error("first drive output not low while driven");
   a_second_high: assert property (drive.drive_out_second_oe |-> drive.drive_out_second_o)
      else $error("second drive output not high while driven");
   a_recessive_float: assert property (!tx_dominant |=>
      !drive.drive_out_first_oe && !drive.drive_out_second_oe)
      else $error("drive enabled for a recessive bit");
   a_drive_gated: assert property (tx_dominant && !interface_enable && !wr |=>
      !drive.drive_out_first_oe && !drive.drive_out_second_oe)
      else $error("drive enabled while interface disabled");
   a_sjw_cap: assert property (s_tim_wr |=> sync_jump_width ==
      (($past(wdata[4:2]) > 3'h3) ? 4'h4 : 4'h1 + $past(wdata[4:2])))
      else $error("jump width wrong for phase field");
   a_wake_fixed: assert property (FIXED_WAKE && $fell(wake_signal) |=> wake_pending)
      else $error("bus wake edge did not set pending");
   a_wake_block: assert property (wake_pending |-> !lowpower_grant)
      else $error("low power granted with wake pending");
   a_grant_free: assert property (lowpower_request && !wake_pending |-> lowpower_grant)
      else $error("low power refused without wake pending");
endmodule : cbt_phy_asserts

// ---- testbench/cbt_bus_node.sv ----
// Far-side model: one other CAN node and the bus wiring.
// Assumes a wired bus where any driver forces dominant.
`timescale 1ns/10ps
module cbt_bus_node (
   input  wire logic                other_dominant,
   input  wire cbt_pkg::cbt_drive_s drive,
   output logic                     cmp_first_above_ref,
   output logic                     cmp_second_above_ref,
   output logic                     cmp_first_above_second,
   output logic                     wake_cmp_first,
   output logic                     wake_cmp_second
);
   logic bus_dom;
   // Own transistors loop back, so the device hears itself
   assign bus_dom = other_dominant | drive.drive_out_first_oe | drive.drive_out_second_oe;
   assign cmp_first_above_ref    = ~bus_dom;
   assign cmp_second_above_ref   = bus_dom;
   assign cmp_first_above_second = ~bus_dom;
   assign wake_cmp_first         = ~bus_dom;
   // Grounded, never at the reference, so no false wake
   assign wake_cmp_second        = 1'b0;
endmodule : cbt_bus_node

// ---- testbench/test_cbt_can_phy.sv ----
// Bench for the CAN pin and bit timing block.
// Drives the strobe register port and a bus node model.
`timescale 1ns/10ps
module test_cbt_can_phy;
   logic                clock, rst_n, wr, rd, tx_dominant, other_dominant;
   logic                lowpower_request, interface_enable, rx_bit, wake_signal;
   logic                wake_pending, lowpower_grant, sample_point, bit_end, irq;
   logic                c_fr, c_sr, c_fs, w_f, w_s;
   logic [3:0]          addr, sync_jump_width;
   logic [7:0]          wdata, rdata, d;
   cbt_pkg::cbt_drive_s drive;
   int                  error_cnt, tests_run, cycles, i, n;
   logic [7:0]          modes [5] = '{8'h30, 8'h18, 8'h24, 8'h28, 8'h14};
   cbt_can_phy i_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .tx_dominant(tx_dominant), .drive(drive),
      .interface_enable(interface_enable), .cmp_first_above_ref(c_fr),
      .cmp_second_above_ref(c_sr), .cmp_first_above_second(c_fs), .wake_cmp_first(w_f),
      .wake_cmp_second(w_s), .rx_bit(rx_bit), .wake_signal(wake_signal),
      .wake_pending(wake_pending), .lowpower_request(lowpower_request),
      .lowpower_grant(lowpower_grant), .sample_point(sample_point), .bit_end(bit_end),
      .sync_jump_width(sync_jump_width), .irq(irq));
   cbt_bus_node i_node (.other_dominant(other_dominant), .drive(drive),
      .cmp_first_above_ref(c_fr), .cmp_second_above_ref(c_sr),
      .cmp_first_above_second(c_fs), .wake_cmp_first(w_f), .wake_cmp_second(w_s));
   always #5 clock = ~clock;
   task summarize;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
      #1;
   endtask : wr_reg
   task rd_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task wait_end;
      do begin @(posedge clock); #1; n++; end while (bit_end !== 1'b1);
   endtask : wait_end
   // Hang guard, well above the longest sequence
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      {clock, rst_n, wr, rd, tx_dominant, other_dominant, lowpower_request} = '0;
      {addr, wdata, error_cnt, tests_run, cycles, n} = '0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      for (i = 0; i < 3; i++) begin
         rd_reg(i[3:0], d);
         check("reset value", d, 8'h00);
      end
      rd_reg(4'hF, d);
      check("unmapped", d, 8'h00);
      for (i = 0; i < 5; i++) begin
         wr_reg(cbt_pkg::ADDR_BUS_PIN_CONTROL, modes[i]);
         check("enable", 8'(interface_enable), 8'h01);
         rd_reg(cbt_pkg::ADDR_BUS_PIN_CONTROL, d);
         check("control", d, modes[i]);
         @(posedge clock) tx_dominant <= 1'b1;
         repeat (3) @(posedge clock);
         #1 check("first oe", 8'(drive.drive_out_first_oe), 8'(modes[i][4]));
         check("second oe", 8'(drive.drive_out_second_oe), 8'(modes[i][5]));
         check("rx dominant", 8'(rx_bit), 8'h00);
         @(posedge clock) tx_dominant <= 1'b0;
         repeat (3) @(posedge clock);
         #1 check("rx recessive", 8'(rx_bit), 8'h01);
      end
      wr_reg(cbt_pkg::ADDR_BUS_PIN_CONTROL, 8'h00);
      check("disabled", 8'(interface_enable), 8'h00);
      // Software keeps bits 6, 1 and 0 while switching mode
      wr_reg(cbt_pkg::ADDR_BUS_PIN_CONTROL, 8'h43);
      rd_reg(cbt_pkg::ADDR_BUS_PIN_CONTROL, d);
      wr_reg(cbt_pkg::ADDR_BUS_PIN_CONTROL, (d & 8'h43) | 8'h30);
      rd_reg(cbt_pkg::ADDR_BUS_PIN_CONTROL, d);
      check("rmw control", d, 8'h73);
      for (i = 0; i < 8; i++) begin
         wr_reg(cbt_pkg::ADDR_BIT_SEGMENT_TIMING, 8'(i << 2));
         check("jump width", 8'(sync_jump_width), (i < 4) ? 8'(i + 1) : 8'h04);
      end
      // Prescaler 1, prop 2, phase 4 quanta: 11 quanta of 2 clocks
      for (i = 0; i < 2; i++) begin
         wr_reg(cbt_pkg::ADDR_BIT_RATE_PRESCALER, (i == 0) ? 8'h01 : 8'h00);
         wr_reg(cbt_pkg::ADDR_BIT_SEGMENT_TIMING, (i == 0) ? 8'h2C : 8'h00);
         wait_end();
         wait_end();
         n = 0;
         wait_end();
         check("bit period", 8'(n), (i == 0) ? 8'd22 : 8'd4);
         // Sample point sits one phase segment before the next bit end
         repeat ((i == 0) ? 14 : 3) @(posedge clock);
         #1 check("sample point", 8'(sample_point), 8'h01);
      end
      for (i = 0; i < 2; i++) begin
         wr_reg(cbt_pkg::ADDR_TX_DATA_FIRST + 4'(i), 8'hA5 ^ 8'(i));
         rd_reg(cbt_pkg::ADDR_TX_DATA_FIRST + 4'(i), d);
         check("tx data", d, 8'hA5 ^ 8'(i));
      end
      wr_reg(cbt_pkg::ADDR_IRQ_ENABLE, 8'h00);
      wr_reg(cbt_pkg::ADDR_IRQ_CLEAR, 8'h03);
      wr_reg(cbt_pkg::ADDR_WAKE_CONTROL, 8'h00);
      rd_reg(cbt_pkg::ADDR_WAKE_CONTROL, d);
      check("wake fixed", 8'(d[0]), 8'h01);
      @(posedge clock) lowpower_request <= 1'b1;
      repeat (2) @(posedge clock);
      #1 check("grant", 8'(lowpower_grant), 8'h01);
      @(posedge clock) other_dominant <= 1'b1;
      repeat (4) @(posedge clock);
      #1 check("pending", 8'(wake_pending), 8'h01);
      check("blocked", 8'(lowpower_grant), 8'h00);
      check("irq masked", 8'(irq), 8'h00);
      wr_reg(cbt_pkg::ADDR_IRQ_ENABLE, 8'h01);
      check("irq set", 8'(irq), 8'h01);
      wr_reg(cbt_pkg::ADDR_IRQ_STATUS, 8'h00);
      rd_reg(cbt_pkg::ADDR_IRQ_STATUS, d);
      check("status ro", 8'(d[0]), 8'h01);
      @(posedge clock) other_dominant <= 1'b0;
      wr_reg(cbt_pkg::ADDR_IRQ_CLEAR, 8'h01);
      check("irq clear", 8'(irq), 8'h00);
      check("unblocked", 8'(lowpower_grant), 8'h01);
      wr_reg(cbt_pkg::ADDR_IRQ_ENABLE, 8'h02);
      check("bit irq", 8'(irq), 8'h01);
      rd_reg(cbt_pkg::ADDR_BIT_STATUS, d);
      check("bit status", 8'(d[7:2]), 8'h04);
      summarize();
   end
endmodule : test_cbt_can_phy
bind cbt_can_phy cbt_phy_asserts #(.FIXED_WAKE(FIXED_WAKE)) i_chk (.clock(clock),
   .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .tx_dominant(tx_dominant),
   .drive(drive), .interface_enable(interface_enable), .wake_signal(wake_signal),
   .wake_pending(wake_pending), .lowpower_request(lowpower_request),
   .lowpower_grant(lowpower_grant), .sync_jump_width(sync_jump_width));
